//--- src/ssi_encoder_register_port.sv
`timescale 1ns/1ps
module ssi_encoder_register_port #(
   // arbitrary values, chosen only to be recognisable
   parameter logic [31:0] IDENT_WORD = 32'h5e1f_0a0b,
   parameter logic [31:0] HW_VERSION = 32'h0000_0001,
   parameter logic [31:0] SW_VERSION = 32'h0000_0001
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic link_clk_in,
   input wire logic ssi_data_in,
   output logic ssi_clk_out,
   input wire logic wr_cmd_in,
   input wire logic [5:0] wr_addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic [5:0] rd_addr_in,
   input wire logic halt_in,
   input wire logic cmp_one_en_in,
   input wire logic cmp_two_en_in,
   output logic write_acknowledge_out,
   output logic write_accepted_out,
   output logic [5:0] rd_addr_out,
   output logic [31:0] rd_data_out,
   output logic rd_abort_out,
   output logic cmp_one_out,
   output logic cmp_two_out,
   output logic [7:0] enc_status_out,
   output logic [2:0] diag_out
);
   // ------------------------------------------------
   // functions
   // ------------------------------------------------
   function automatic logic [31:0] gray_to_bin(input logic [31:0] g);
      logic [31:0] b;
      b = 32'h0000_0000;
      b[31] = g[31];
      for (int i = 30; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   function automatic logic para_ok(input logic [31:0] p);
      logic [5:0] len;
      logic [6:0] trim;
      len = p[ssi_pkg::FLD_LEN_LO +: 6];
      trim = {1'b0, p[ssi_pkg::FLD_MSB_LO +: 6]} + {1'b0, p[ssi_pkg::FLD_LSB_LO +: 6]};
      return (len != 6'h00) && (len <= ssi_pkg::LEN_MAX) &&
         (p[ssi_pkg::FLD_RATE_LO +: 3] <= ssi_pkg::RATE_SLOWEST) && (trim < {1'b0, len});
   endfunction

   // ------------------------------------------------
   // declarations
   // ------------------------------------------------
   logic ack_r;
   logic acc_r;
   logic param_err_r;
   logic [31:0] sf_r;
   logic [31:0] para_r;
   logic [31:0] cmp_val_r [2];
   logic [1:0] cmp_res_r;
   logic [1:0] cmp_en;
   logic [1:0] hit_cmp;
   logic hit_sf;
   logic hit_para;
   logic wr_go;
   logic wr_ok;
   logic [31:0] pos_r;
   logic [31:0] gray_r;
   logic [31:0] frame_r;
   logic [7:0] status_r;
   logic frame_err_r;
   logic [2:0] diag_r;
   logic cfg_req_r;
   logic [9:0] cfg_sent_r;
   logic [9:0] cfg_now;
   logic [1:0] ack_sync_r;
   logic [2:0] tgl_sync_r;
   logic cfg_idle;
   logic cfg_ack;
   logic frame_tgl;
   logic frame_new;
   logic [31:0] link_frame;
   logic link_err;
   logic [5:0] len_cur;
   logic [5:0] msb_cur;
   logic [5:0] lsb_cur;
   logic [5:0] keep_len;
   logic gray_mode;
   logic [32:0] keep_mask;
   logic [32:0] stat_mask;
   logic [31:0] trimmed;
   logic [31:0] status_bits;
   logic [31:0] bin_val;
   logic [31:0] gray_val;
   logic rd_hit;
   logic [31:0] rd_word;

   localparam logic [9:0] CFG_RST = {1'b1, ssi_pkg::LEN_RST, ssi_pkg::RATE_RST};

   // ------------------------------------------------
   // link side, on its own clock
   // ------------------------------------------------
   ssi_link link_u (
      .link_clk_in(link_clk_in),
      .rst_n_in(rst_n_in),
      .cfg_req_in(cfg_req_r),
      .cfg_len_in(cfg_sent_r[8:3]),
      .cfg_rate_in(cfg_sent_r[2:0]),
      .cfg_halt_in(cfg_sent_r[9]),
      .ssi_data_in(ssi_data_in),
      .cfg_ack_out(cfg_ack),
      .ssi_clk_out(ssi_clk_out),
      .frame_out(link_frame),
      .frame_err_out(link_err),
      .frame_tgl_out(frame_tgl)
   );

   // ------------------------------------------------
   // config handshake toward the link
   // ------------------------------------------------
   // halt request travels with the link settings
   assign cfg_now = {halt_in, para_r[ssi_pkg::FLD_LEN_LO +: 6], para_r[ssi_pkg::FLD_RATE_LO +: 3]};
   assign cfg_idle = (cfg_req_r == ack_sync_r[1]);

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         ack_sync_r <= 2'h0;
         tgl_sync_r <= 3'h0;
      end else begin
         ack_sync_r <= {ack_sync_r[0], cfg_ack};
         tgl_sync_r <= {tgl_sync_r[1:0], frame_tgl};
      end
   end

   // one word in flight; later changes wait for the acknowledge
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         cfg_req_r <= 1'b0;
         cfg_sent_r <= CFG_RST;
      end else if (cfg_idle && cfg_now != cfg_sent_r) begin
         cfg_sent_r <= cfg_now;
         cfg_req_r <= !cfg_req_r;
      end
   end

   // ------------------------------------------------
   // frame decoding
   // ------------------------------------------------
   assign frame_new = tgl_sync_r[1] ^ tgl_sync_r[2];
   assign len_cur = para_r[ssi_pkg::FLD_LEN_LO +: 6];
   assign msb_cur = para_r[ssi_pkg::FLD_MSB_LO +: 6];
   assign lsb_cur = para_r[ssi_pkg::FLD_LSB_LO +: 6];
   assign gray_mode = para_r[ssi_pkg::FLD_GRAY];
   assign keep_len = len_cur - msb_cur;
   assign keep_mask = (33'h0_0000_0001 << keep_len) - 33'h0_0000_0001;
   // low invalid bits shifted out, zeros fill
   assign trimmed = (link_frame & keep_mask[31:0]) >> lsb_cur;
   // dropped low bits carry encoder status
   assign stat_mask = (33'h0_0000_0001 << lsb_cur) - 33'h0_0000_0001;
   assign status_bits = link_frame & stat_mask[31:0];
   assign bin_val = gray_mode ? gray_to_bin(trimmed) : trimmed;
   assign gray_val = gray_mode ? trimmed : trimmed ^ (trimmed >> 1);

   // all frame views latch on one edge
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         pos_r <= 32'h0000_0000;
         gray_r <= 32'h0000_0000;
         frame_r <= 32'h0000_0000;
         status_r <= 8'h00;
         frame_err_r <= 1'b0;
      end else if (frame_new) begin
         pos_r <= bin_val;
         gray_r <= gray_val;
         frame_r <= link_frame;
         status_r <= status_bits[7:0];
         frame_err_r <= link_err;
      end
   end

   // ------------------------------------------------
   // register writes
   // ------------------------------------------------
   assign hit_sf = (wr_addr_in == ssi_pkg::OFS_SPECIAL_FUNCTION);
   assign hit_para = (wr_addr_in == ssi_pkg::OFS_LINK_PARAMETERS);
   assign hit_cmp[0] = (wr_addr_in == ssi_pkg::OFS_COMPARE_VALUE_ONE);
   assign hit_cmp[1] = (wr_addr_in == ssi_pkg::OFS_COMPARE_VALUE_TWO);
   assign wr_ok = hit_sf || (hit_para && para_ok(wr_data_in)) || (|hit_cmp);
   // only the first cycle of a held command
   assign wr_go = wr_cmd_in && !ack_r;

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         ack_r <= 1'b0;
         acc_r <= 1'b0;
      end else begin
         // acknowledge stands while the command is held
         // dropping the command returns it to zero
         ack_r <= wr_cmd_in;
         if (wr_go) begin
            acc_r <= wr_ok;
         end
      end
   end

   // address and data taken with the command
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         sf_r <= ssi_pkg::SPECIAL_FUNCTION_RST;
         para_r <= ssi_pkg::LINK_PARAMETERS_RST;
      end else if (wr_go && wr_ok) begin
         if (hit_sf) begin
            sf_r <= wr_data_in;
         end
         if (hit_para) begin
            para_r <= wr_data_in;
         end
      end
   end

   // parameter error stays until a good link parameters write
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         param_err_r <= 1'b0;
      end else if (wr_go && hit_para) begin
         param_err_r <= !wr_ok;
      end
   end

   // ------------------------------------------------
   // comparisons
   // ------------------------------------------------
   assign cmp_en = {cmp_two_en_in, cmp_one_en_in};

   for (genvar k = 0; k < 2; k++) begin : g_cmp
      always_ff @(posedge ref_clk_in) begin
         if (!rst_n_in) begin
            cmp_val_r[k] <= ssi_pkg::COMPARE_VALUE_RST;
            cmp_res_r[k] <= 1'b0;
         end else begin
            if (wr_go && hit_cmp[k]) begin
               cmp_val_r[k] <= wr_data_in;
            end
            cmp_res_r[k] <= cmp_en[k] && (pos_r >= cmp_val_r[k]);
         end
      end
   end

   // ------------------------------------------------
   // register reads
   // ------------------------------------------------
   // 64 locations, position and frame map
   always_comb begin
      rd_hit = 1'b1;
      rd_word = 32'h0000_0000;
      unique case (rd_addr_in)
         ssi_pkg::OFS_BINARY_POSITION: rd_word = pos_r;
         ssi_pkg::OFS_IDENTIFICATION_WORD: rd_word = IDENT_WORD;
         ssi_pkg::OFS_HARDWARE_VERSION: rd_word = HW_VERSION;
         ssi_pkg::OFS_SOFTWARE_VERSION: rd_word = SW_VERSION;
         ssi_pkg::OFS_SPECIAL_FUNCTION: rd_word = sf_r;
         ssi_pkg::OFS_OUT_POINTER: rd_word = {26'h000_0000, wr_addr_in};
         ssi_pkg::OFS_IN_POINTER: rd_word = {26'h000_0000, rd_addr_in};
         ssi_pkg::OFS_DIAGNOSTIC_WORD: rd_word = {29'h0000_0000, diag_r};
         ssi_pkg::OFS_LINK_PARAMETERS: rd_word = para_r;
         ssi_pkg::OFS_GRAY_POSITION: rd_word = gray_r;
         ssi_pkg::OFS_RAW_FRAME: rd_word = frame_r;
         ssi_pkg::OFS_COMPARE_VALUE_ONE: rd_word = cmp_val_r[0];
         ssi_pkg::OFS_COMPARE_VALUE_TWO: rd_word = cmp_val_r[1];
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         rd_addr_out <= 6'h00;
         rd_data_out <= 32'h0000_0000;
         rd_abort_out <= 1'b0;
         diag_r <= 3'h0;
      end else begin
         // data on success, abort on failure
         rd_abort_out <= !rd_hit;
         // address echoed, data forced to zero on failure
         rd_addr_out <= rd_addr_in;
         rd_data_out <= rd_hit ? rd_word : 32'h0000_0000;
         diag_r[ssi_pkg::DIAG_PARAM_ERR] <= param_err_r;
         diag_r[ssi_pkg::DIAG_FRAME_ERR] <= frame_err_r;
         diag_r[ssi_pkg::DIAG_HALTED] <= cfg_sent_r[9];
      end
   end

   assign write_acknowledge_out = ack_r;
   assign write_accepted_out = acc_r;
   assign cmp_one_out = cmp_res_r[0];
   assign cmp_two_out = cmp_res_r[1];
   assign enc_status_out = status_r;
   assign diag_out = diag_r;

   // ------------------------------------------------
   // checks
   // ------------------------------------------------
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   chk_write_ack_rise: assert property (
      wr_cmd_in && !write_acknowledge_out |=> write_acknowledge_out)
      else $error("write command not acknowledged");

   chk_write_ack_fall: assert property (
      !wr_cmd_in |=> !write_acknowledge_out)
      else $error("acknowledge stayed high after command");

   chk_single_write: assert property (
      write_acknowledge_out |=> $stable(para_r) && $stable(sf_r) && $stable(cmp_val_r[0]))
      else $error("held command wrote again");

   chk_refuse_readonly: assert property (
      wr_cmd_in && !write_acknowledge_out && wr_addr_in == ssi_pkg::OFS_RAW_FRAME
      |=> write_acknowledge_out && !write_accepted_out && ($stable(frame_r) || $past(frame_new)))
      else $error("read-only register accepted a write");

   chk_accept_compare: assert property (
      wr_cmd_in && !write_acknowledge_out && wr_addr_in == ssi_pkg::OFS_COMPARE_VALUE_TWO
      |=> write_accepted_out && cmp_val_r[1] == $past(wr_data_in))
      else $error("compare write not accepted");

   chk_abort_zero: assert property (
      rd_abort_out |-> rd_data_out == 32'h0000_0000)
      else $error("failed read returned data");

   chk_read_echo: assert property (
      ##1 rd_addr_out == $past(rd_addr_in))
      else $error("read address not echoed");

   chk_read_reserved: assert property (
      rd_addr_in == 6'h05 || rd_addr_in == 6'h3f |=> rd_abort_out)
      else $error("reserved read did not abort");

   chk_read_position: assert property (
      rd_addr_in == ssi_pkg::OFS_BINARY_POSITION |=> !rd_abort_out && rd_data_out == $past(pos_r))
      else $error("position read wrong");

   chk_frame_together: assert property (
      !frame_new |=> $stable(pos_r) && $stable(gray_r) && $stable(frame_r))
      else $error("frame registers changed apart");

   chk_compare_off: assert property (
      (!cmp_one_en_in |=> !cmp_one_out) and (!cmp_two_en_in |=> !cmp_two_out))
      else $error("disabled compare reported");

   chk_param_error: assert property (
      wr_cmd_in && !write_acknowledge_out && hit_para && !para_ok(wr_data_in)
      |=> ##1 diag_out[ssi_pkg::DIAG_PARAM_ERR])
      else $error("parameter error not shown");
endmodule

//--- src/ssi_link.sv
`timescale 1ns/1ps
module ssi_link (
   input wire logic link_clk_in,
   input wire logic rst_n_in,
   input wire logic cfg_req_in,
   input wire logic [5:0] cfg_len_in,
   input wire logic [2:0] cfg_rate_in,
   input wire logic cfg_halt_in,
   input wire logic ssi_data_in,
   output logic cfg_ack_out,
   output logic ssi_clk_out,
   output logic [31:0] frame_out,
   output logic frame_err_out,
   output logic frame_tgl_out
);
   logic [1:0] rst_sync_r;
   logic [1:0] data_sync_r;
   logic [2:0] req_sync_r;
   logic link_rst_n;
   ssi_pkg::link_state_e st_r;
   logic [ssi_pkg::CNT_W-1:0] cnt_r;
   logic [ssi_pkg::CNT_W-1:0] half_last;
   logic [5:0] len_r;
   logic [5:0] bits_r;
   logic [2:0] rate_r;
   logic halt_r;
   logic phase_r;
   logic err_r;
   logic [31:0] shreg_r;
   logic [31:0] shreg_nxt;
   logic cnt_end;
   logic last_bit;
   logic req_edge;

   assign link_rst_n = rst_sync_r[1];
   assign req_edge = req_sync_r[1] ^ req_sync_r[2];
   // half bit doubles per rate step
   assign half_last = (ssi_pkg::HALF_FAST_CNT << rate_r) - ssi_pkg::CNT_ONE;
   assign cnt_end = (cnt_r == half_last);
   assign shreg_nxt = {shreg_r[30:0], data_sync_r[1]};
   assign last_bit = (bits_r == 6'h01);

   always_ff @(posedge link_clk_in) begin
      rst_sync_r <= {rst_sync_r[0], rst_n_in};
      data_sync_r <= {data_sync_r[0], ssi_data_in};
   end

   // config word is held still by the sender until acknowledged
   always_ff @(posedge link_clk_in) begin
      if (!link_rst_n) begin
         req_sync_r <= 3'h0;
         cfg_ack_out <= 1'b0;
         len_r <= ssi_pkg::LEN_RST;
         rate_r <= ssi_pkg::RATE_RST;
         halt_r <= 1'b1;
      end else begin
         req_sync_r <= {req_sync_r[1:0], cfg_req_in};
         if (req_edge) begin
            len_r <= cfg_len_in;
            rate_r <= cfg_rate_in;
            halt_r <= cfg_halt_in;
            cfg_ack_out <= req_sync_r[1];
         end
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (!link_rst_n) begin
         st_r <= ssi_pkg::ST_IDLE;
         cnt_r <= '0;
         bits_r <= 6'h00;
         phase_r <= 1'b0;
         ssi_clk_out <= 1'b1;
         shreg_r <= 32'h0000_0000;
         err_r <= 1'b0;
         frame_out <= 32'h0000_0000;
         frame_err_out <= 1'b0;
         frame_tgl_out <= 1'b0;
      end else begin
         unique case (st_r)
            ssi_pkg::ST_IDLE: begin
               cnt_r <= '0;
               if (!halt_r) begin
                  // idle data line low means no encoder answering
                  err_r <= !data_sync_r[1];
                  bits_r <= len_r;
                  shreg_r <= 32'h0000_0000;
                  phase_r <= 1'b0;
                  ssi_clk_out <= 1'b0;
                  st_r <= ssi_pkg::ST_SHIFT;
               end
            end
            ssi_pkg::ST_SHIFT: begin
               cnt_r <= cnt_end ? '0 : cnt_r + ssi_pkg::CNT_ONE;
               if (cnt_end && !phase_r) begin
                  ssi_clk_out <= 1'b1;
                  phase_r <= 1'b1;
               end
               if (cnt_end && phase_r) begin
                  shreg_r <= shreg_nxt;
                  bits_r <= bits_r - 6'h01;
                  phase_r <= 1'b0;
                  if (last_bit) begin
                     frame_out <= shreg_nxt;
                     frame_err_out <= err_r;
                     frame_tgl_out <= !frame_tgl_out;
                     st_r <= ssi_pkg::ST_PAUSE;
                  end else begin
                     ssi_clk_out <= 1'b0;
                  end
               end
            end
            ssi_pkg::ST_PAUSE: begin
               // encoder needs a quiet gap before the next frame
               cnt_r <= cnt_r + ssi_pkg::CNT_ONE;
               if (cnt_r == ssi_pkg::PAUSE_LAST_CNT) begin
                  st_r <= ssi_pkg::ST_IDLE;
               end
            end
            default: begin
               st_r <= ssi_pkg::ST_IDLE;
            end
         endcase
      end
   end

   chk_idle_clock_high: assert property (
      @(posedge link_clk_in) disable iff (!link_rst_n)
      st_r == ssi_pkg::ST_IDLE |-> ssi_clk_out)
      else $error("serial clock not high while idle");

   chk_clock_rise: assert property (
      @(posedge link_clk_in) disable iff (!link_rst_n)
      st_r == ssi_pkg::ST_SHIFT && cnt_end && !phase_r |=> ssi_clk_out && cnt_r == '0)
      else $error("serial clock did not rise at half bit");

   chk_frame_publish: assert property (
      @(posedge link_clk_in) disable iff (!link_rst_n)
      st_r == ssi_pkg::ST_SHIFT && cnt_end && phase_r && last_bit
      |=> $changed(frame_tgl_out) && st_r == ssi_pkg::ST_PAUSE)
      else $error("frame end not published");
endmodule

//--- src/ssi_pkg.sv
// How it works
// - frame length one to thirty-two bits
// - serial rate 62.5 kbit/s to 1 Mbit/s
// - device drives clock, encoder shifts data
// - gray or binary frames by configuration
// - invalid high bits masked to zero
// - invalid low bits shifted out right
// - output data halts link, enables compares
// - sixty-four addressable 32-bit register locations
// - write acknowledge raised after processing
// - accept flag shows success or refusal
// - read data returned, abort cleared
// - unreadable register raises read abort
// - failed read echoes address, zero data
// - positions, raw frame at 0, 32, 33
// - enabled compare results in input data
// - encoder status bits forwarded to controller
// - diagnostics, parameter errors in input data
package ssi_pkg;
   // ------------------------------------------------
   // widths and register indices
   // ------------------------------------------------
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam int STATUS_W = 8;
   localparam int DIAG_W = 3;
   localparam logic [5:0] OFS_BINARY_POSITION = 6'h00;
   localparam logic [5:0] OFS_IDENTIFICATION_WORD = 6'h01;
   localparam logic [5:0] OFS_HARDWARE_VERSION = 6'h02;
   localparam logic [5:0] OFS_SOFTWARE_VERSION = 6'h03;
   localparam logic [5:0] OFS_SPECIAL_FUNCTION = 6'h04;
   localparam logic [5:0] OFS_OUT_POINTER = 6'h0e;
   localparam logic [5:0] OFS_IN_POINTER = 6'h0f;
   localparam logic [5:0] OFS_DIAGNOSTIC_WORD = 6'h10;
   localparam logic [5:0] OFS_LINK_PARAMETERS = 6'h14;
   localparam logic [5:0] OFS_GRAY_POSITION = 6'h20;
   localparam logic [5:0] OFS_RAW_FRAME = 6'h21;
   localparam logic [5:0] OFS_COMPARE_VALUE_ONE = 6'h22;
   localparam logic [5:0] OFS_COMPARE_VALUE_TWO = 6'h23;
   // ------------------------------------------------
   // reset values and link_parameters fields
   // ------------------------------------------------
   localparam logic [31:0] LINK_PARAMETERS_RST = 32'h1901_0000;
   localparam logic [31:0] COMPARE_VALUE_RST = 32'h0000_0000;
   localparam logic [31:0] SPECIAL_FUNCTION_RST = 32'h0000_0000;
   localparam int FLD_LSB_LO = 0;
   localparam int FLD_MSB_LO = 8;
   localparam int FLD_RATE_LO = 16;
   localparam int FLD_GRAY = 20;
   localparam int FLD_LEN_LO = 24;
   localparam logic [2:0] RATE_SLOWEST = 3'h4;
   localparam logic [5:0] LEN_MAX = 6'h20;
   localparam logic [5:0] LEN_RST = LINK_PARAMETERS_RST[29:24];
   localparam logic [2:0] RATE_RST = LINK_PARAMETERS_RST[18:16];
   localparam int DIAG_PARAM_ERR = 0;
   localparam int DIAG_FRAME_ERR = 1;
   localparam int DIAG_HALTED = 2;
   // ------------------------------------------------
   // link timing, counted on the link clock
   // ------------------------------------------------
   localparam int CNT_W = 12;
   localparam int LINK_PERIOD_PS = 6000;
   localparam int HALF_BIT_FAST_NS = 500;
   localparam int PAUSE_NS = 20000;
   localparam int HALF_FAST_CYC = (HALF_BIT_FAST_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam int PAUSE_LAST = (PAUSE_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS - 1;
   localparam logic [CNT_W-1:0] HALF_FAST_CNT = HALF_FAST_CYC[CNT_W-1:0];
   localparam logic [CNT_W-1:0] PAUSE_LAST_CNT = PAUSE_LAST[CNT_W-1:0];
   localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_PAUSE = 3'b100
   } link_state_e;
endpackage

//--- verification/ssi_encoder_model.sv
`timescale 1ns/1ps
module ssi_encoder_model (
   input wire logic ssi_clk_in,
   input wire logic [5:0] len_in,
   input wire logic [31:0] word_in,
   output logic ssi_data_out
);
   int n = 0;
   initial ssi_data_out = 1'b1;
   // frame starts on first falling clock
   always @(negedge ssi_clk_in) begin
      if (n == 0) n = len_in;
   end
   // msb first, new bit on each rising clock
   always @(posedge ssi_clk_in) begin
      if (n > 0) begin
         n = n - 1;
         ssi_data_out = word_in[n];
         // line idles high once the hold time is over; longer than the slowest half bit
         if (n == 0) ssi_data_out <= #15000 1'b1;
      end
   end
endmodule

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic ref_clk_in = 1'b0, link_clk_in = 1'b0, rst_n_in = 1'b0, wr_cmd_in = 1'b0, halt_in = 1'b0;
   logic cmp_one_en_in = 1'b0, cmp_two_en_in = 1'b0, ssi_data, ssi_clk, ack, acc, abort, c1, c2;
   logic [5:0] wr_addr_in = 6'h00, rd_addr_in = 6'h00, rd_addr_out, len_cfg = 6'h19;
   logic [31:0] wr_data_in = 32'h0, rd_data_out, t, g;
   logic [7:0] enc_status_out;
   logic [2:0] diag_out;
   logic [31:0] bad [4] = '{32'h0000_0000, 32'h2100_0000, 32'h1905_0000, 32'h1000_0808};
   logic [31:0] good [4] = '{32'h2000_0000, 32'h0100_0000, 32'h1004_0203, 32'h1000_0203};
   int n_fail = 0, total_checks = 0, k;
   initial forever #5 ref_clk_in = ~ref_clk_in;
   // link clock offset so the two domains never line up
   initial begin
      #1.3;
      forever #3 link_clk_in = ~link_clk_in;
   end
   ssi_encoder_register_port dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk_in),
      .ssi_data_in(ssi_data), .ssi_clk_out(ssi_clk), .wr_cmd_in(wr_cmd_in), .wr_addr_in(wr_addr_in),
      .wr_data_in(wr_data_in), .rd_addr_in(rd_addr_in), .halt_in(halt_in), .cmp_one_en_in(cmp_one_en_in),
      .cmp_two_en_in(cmp_two_en_in), .write_acknowledge_out(ack), .write_accepted_out(acc),
      .rd_addr_out(rd_addr_out), .rd_data_out(rd_data_out), .rd_abort_out(abort), .cmp_one_out(c1),
      .cmp_two_out(c2), .enc_status_out(enc_status_out), .diag_out(diag_out));
   ssi_encoder_model enc (.ssi_clk_in(ssi_clk), .len_in(len_cfg), .word_in(32'h00b6_b6a5),
      .ssi_data_out(ssi_data));
   // ------------------------------------------------
   // access tasks
   // ------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d, failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wait_ack(input logic v);
      for (k = 0; k < 50 && ack !== v; k++) @(posedge ref_clk_in) #1;
      if (ack !== v) begin
         n_fail++;
         $display("Error at %0t: acknowledge timeout", $time);
         wrap_up();
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic exp_acc);
      wait_ack(1'b0);
      @(posedge ref_clk_in);
      wr_addr_in <= a;
      wr_data_in <= d;
      wr_cmd_in <= 1'b1;
      @(posedge ref_clk_in) #1;
      wait_ack(1'b1);
      chk(acc, exp_acc, "accept flag");
      @(posedge ref_clk_in);
      wr_cmd_in <= 1'b0;
      #1 wait_ack(1'b0);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] d, input logic ab);
      @(posedge ref_clk_in);
      rd_addr_in <= a;
      repeat (2) @(posedge ref_clk_in);
      #1 chk(rd_data_out, d, "read data");
      chk({abort, rd_addr_out}, {ab, a}, "abort and address echo");
   endtask
   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial begin
      repeat (10) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      rd(6'h14, 32'h1901_0000, 1'b0);
      rd(6'h22, 32'h0, 1'b0);
      rd(6'h01, 32'h5e1f_0a0b, 1'b0);
      rd(6'h05, 32'h0, 1'b1);
      rd(6'h3f, 32'h0, 1'b1);
      wr(6'h00, 32'h1, 1'b0);
      wr(6'h21, 32'h1, 1'b0);
      foreach (bad[i]) wr(6'h14, bad[i], 1'b0);
      chk(diag_out[0], 1'b1, "parameter error");
      rd(6'h14, 32'h1901_0000, 1'b0);
      foreach (good[i]) wr(6'h14, good[i], 1'b1);
      chk(diag_out[0], 1'b0, "parameter error");
      // held command with changed data must not write twice
      @(posedge ref_clk_in);
      wr_addr_in <= 6'h04;
      wr_data_in <= 32'h0000_0011;
      wr_cmd_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      wr_data_in <= 32'h0000_0022;
      repeat (2) @(posedge ref_clk_in);
      wr_cmd_in <= 1'b0;
      rd(6'h04, 32'h0000_0011, 1'b0);
      $display("register test done");
      len_cfg = 6'h10;
      t = (32'hb6a5 & 32'h3fff) >> 3;
      wr(6'h22, t, 1'b1);
      wr(6'h23, t + 1, 1'b1);
      cmp_one_en_in <= 1'b1;
      cmp_two_en_in <= 1'b1;
      repeat (9000) @(posedge ref_clk_in);
      rd(6'h21, 32'hb6a5, 1'b0);
      rd(6'h00, t, 1'b0);
      rd(6'h20, t ^ (t >> 1), 1'b0);
      chk(enc_status_out, 8'h05, "encoder status");
      chk({c1, c2, diag_out[1]}, 3'b100, "compare and frame flags");
      cmp_one_en_in <= 1'b0;
      wr(6'h14, 32'h1010_0203, 1'b1);
      chk(c1, 1'b0, "compare disabled");
      repeat (9000) @(posedge ref_clk_in);
      g = t;
      for (k = 1; k < 32; k++) g = g ^ (t >> k);
      rd(6'h00, g, 1'b0);
      rd(6'h20, t, 1'b0);
      $display("frame test done");
      halt_in <= 1'b1;
      repeat (9000) @(posedge ref_clk_in);
      chk({diag_out[2], ssi_clk}, 2'b11, "halted link");
      $display("halt test done");
      wrap_up();
   end
endmodule
